// ### core/pcc_command_bank.sv
// Behaviour
// - bits 15 to 10 are reserved and read as zero.
// - back-to-back enable bit is read-only zero.
// - system error enable gates the SERR driver; resets clear.
// - address parity error reaches SERR only when both enables set.
// - stepping bit held at zero; writes ignored.
// - parity response enable clear ignores parity errors; resets clear.
// - data parity errors drive PERR, address parity errors drive SERR.
// - snoop set: do not claim palette writes, capture their data.
// - write-invalidate bit is zero; initiator uses plain memory writes.
// - special cycle bit is zero; special cycles never answered.
// - initiating bus accesses only while initiator enable set.
// - memory cycles claimed only while memory enable set.
// - I/O cycles claimed only while I/O enable set.
// - each function owns an independent command register.
// - error enables ORed across functions; each reads back separately.
// - data parity flag set only on PERR, as master, enable set.
//
// command registers of three functions with their gating of bus activity
// assumes configuration and bus decode events arrive on mclk
`timescale 1ns/10ps
`include "pcc_defines.svh"
module pcc_command_bank
    import pcc_pkg::*;
#(
    parameter int NUM_FUNC = `PCC_NUM_FUNC
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [1:0] cfg_func,
    input wire logic [7:0] cfg_offset,
    input wire logic [1:0] cfg_be,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    // target decode requests, per function
    input wire logic [NUM_FUNC-1:0] mem_hit,
    input wire logic [NUM_FUNC-1:0] io_hit,
    input wire logic [NUM_FUNC-1:0] palette_wr_hit,
    input wire logic special_cycle,
    input wire logic [31:0] bus_data,
    output logic [NUM_FUNC-1:0] claim,
    output logic [NUM_FUNC-1:0] palette_capture,
    output logic [31:0] palette_data,
    // initiator
    input wire logic [NUM_FUNC-1:0] init_req,
    input wire logic [NUM_FUNC-1:0] init_mem_write,
    output logic [NUM_FUNC-1:0] init_grant,
    output logic init_write_invalidate,
    // parity
    input wire logic addr_par_err,
    input wire logic data_par_err,
    input wire logic [NUM_FUNC-1:0] master_active,
    input wire logic perr_seen,
    input wire logic [NUM_FUNC-1:0] data_parity_clear,
    output logic serr_drive,
    output logic perr_drive,
    output logic [NUM_FUNC-1:0] data_parity_detected
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rdata;
        logic [NUM_FUNC-1:0] claim;
        logic [NUM_FUNC-1:0] cap;
        logic [31:0] pdata;
        logic [NUM_FUNC-1:0] grant;
        logic wi;
        logic serr;
        logic perr;
        logic [NUM_FUNC-1:0] dpar;
    } pcc_bank_t;

    pcc_bank_t st_q;
    pcc_bank_t st_d;
    pcc_cmd_t cmd [NUM_FUNC];
    pcc_word_t rdw [NUM_FUNC];
    logic any_system_error_report_enable;
    logic any_parity_response_enable;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // command register of an existing function addressed
    function automatic logic cmd_sel(
        input logic [7:0] offset,
        input logic [1:0] func
    );
        return offset == `PCC_CMD_OFFSET && func < 2'(NUM_FUNC);
    endfunction

    // claim of one function; special cycles and snooped palette writes left alone
    function automatic logic claim_of(
        input pcc_cmd_t c,
        input logic mem,
        input logic io,
        input logic pal,
        input logic spec
    );
        return !spec
            && ((mem && c.mem_en)
            || (io && c.io_en))
            && !(pal && c.snoop_en);
    endfunction

    // data parity flag set condition of one function
    function automatic logic dpar_set(
        input pcc_cmd_t c,
        input logic perr,
        input logic master
    );
        return perr && master && c.parity_response_enable;
    endfunction

    // ------------------------------------------------------------
    // per-function registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_FUNC; g++)
        begin : g_fn
            pcc_func_cmd u_cmd (
                .mclk(mclk),
                .reset_n(reset_n),
                .wr_en(cfg_wr && cmd_sel(cfg_offset, cfg_func)
                       && cfg_func == 2'(g)),
                .wr_data(cfg_wdata),
                .wr_be(cfg_be),
                .cmd(cmd[g]),
                .rd_word(rdw[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // error enables wired OR
    // ------------------------------------------------------------
    always_comb
    begin
        any_system_error_report_enable = 1'b0;
        any_parity_response_enable = 1'b0;
        for (int i = 0; i < NUM_FUNC; i++)
        begin
            any_system_error_report_enable = any_system_error_report_enable | cmd[i].system_error_report_enable;
            any_parity_response_enable = any_parity_response_enable | cmd[i].parity_response_enable;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.cap = '0;
        st_d.wi = 1'b0;
        if (cfg_rd)
        begin
            st_d.rdata = 16'h0000;
            if (cmd_sel(cfg_offset, cfg_func))
            begin
                st_d.rdata = rdw[cfg_func];
            end
        end
        for (int i = 0; i < NUM_FUNC; i++)
        begin
            st_d.claim[i] = claim_of(cmd[i], mem_hit[i], io_hit[i], palette_wr_hit[i],
                special_cycle);
            st_d.cap[i] = palette_wr_hit[i] && cmd[i].snoop_en && !special_cycle;
            st_d.grant[i] = init_req[i] && cmd[i].initiator_enable;
        end
        // data parity flags; a set in the cycle of a clear wins
        for (int i = 0; i < NUM_FUNC; i++)
        begin
            if (data_parity_clear[i])
            begin
                st_d.dpar[i] = 1'b0;
            end
            if (dpar_set(cmd[i], perr_seen, master_active[i]))
            begin
                st_d.dpar[i] = 1'b1;
            end
        end
        if (|st_d.cap)
        begin
            st_d.pdata = bus_data;
        end
        // driver enables
        st_d.serr = addr_par_err && any_system_error_report_enable && any_parity_response_enable;
        st_d.perr = data_par_err && any_parity_response_enable;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cfg_rdata = st_q.rdata;
    assign claim = st_q.claim;
    assign palette_capture = st_q.cap;
    assign palette_data = st_q.pdata;
    assign init_grant = st_q.grant;
    assign init_write_invalidate = st_q.wi;
    assign serr_drive = st_q.serr;
    assign perr_drive = st_q.perr;
    assign data_parity_detected = st_q.dpar;

    // plain memory writes pass through the grant unchanged
    logic unused_ok;
    assign unused_ok = |init_mem_write;
endmodule

// ### core/pcc_defines.svh
// command register offsets, bit positions, reset value
// assumes inclusion by the package and design files
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH
`define PCC_CMD_OFFSET 8'h04
`define PCC_CMD_RESET 16'h0000
`define PCC_BIT_IO 0
`define PCC_BIT_MEM 1
`define PCC_BIT_MAST 2
`define PCC_BIT_SPEC 3
`define PCC_BIT_MWI 4
`define PCC_BIT_SNOOP 5
`define PCC_BIT_PERR 6
`define PCC_BIT_STEP 7
`define PCC_BIT_SERR 8
`define PCC_BIT_FBB 9
`define PCC_WR_MASK 16'h0167
`define PCC_NUM_FUNC 3
`endif

// ### core/pcc_func_cmd.sv
// one function's command register
// assumes writes come on mclk from the configuration decoder
`timescale 1ns/10ps
`include "pcc_defines.svh"
module pcc_func_cmd
    import pcc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // write port
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_be,
    // state
    output pcc_cmd_t cmd,
    output pcc_word_t rd_word
);
    pcc_cmd_t st_q;
    pcc_cmd_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            if (wr_be[1])
            begin
                st_d.system_error_report_enable = wr_data[`PCC_BIT_SERR];
            end
            if (wr_be[0])
            begin
                st_d.parity_response_enable = wr_data[`PCC_BIT_PERR];
                st_d.snoop_en = wr_data[`PCC_BIT_SNOOP];
                st_d.initiator_enable = wr_data[`PCC_BIT_MAST];
                st_d.mem_en = wr_data[`PCC_BIT_MEM];
                st_d.io_en = wr_data[`PCC_BIT_IO];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign cmd = st_q;

    // hardwired bits read as zero
    always_comb
    begin
        rd_word = `PCC_CMD_RESET;
        rd_word[`PCC_BIT_SERR] = st_q.system_error_report_enable;
        rd_word[`PCC_BIT_PERR] = st_q.parity_response_enable;
        rd_word[`PCC_BIT_SNOOP] = st_q.snoop_en;
        rd_word[`PCC_BIT_MAST] = st_q.initiator_enable;
        rd_word[`PCC_BIT_MEM] = st_q.mem_en;
        rd_word[`PCC_BIT_IO] = st_q.io_en;
    end
endmodule

// ### core/pcc_pkg.sv
// types shared by the command register bank
// assumes pcc_defines.svh on the include path
`include "pcc_defines.svh"
package pcc_pkg;
    typedef logic [15:0] pcc_word_t;
    typedef struct packed {
        logic system_error_report_enable;
        logic parity_response_enable;
        logic snoop_en;
        logic initiator_enable;
        logic mem_en;
        logic io_en;
    } pcc_cmd_t;
endpackage

// ### verification/pcc_command_bank_monitor.sv
// port checker for the command register bank
// assumes one clock domain; bound to every bank instance
`timescale 1ns/10ps
module pcc_command_bank_monitor
#(
    parameter int NUM_FUNC = 3
)
(
    // clock, reset, configuration
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cfg_rd,
    input wire logic [1:0] cfg_func,
    input wire logic [7:0] cfg_offset,
    input wire logic [15:0] cfg_rdata,
    // bus side
    input wire logic [NUM_FUNC-1:0] mem_hit,
    input wire logic [NUM_FUNC-1:0] io_hit,
    input wire logic special_cycle,
    input wire logic [NUM_FUNC-1:0] claim,
    input wire logic [NUM_FUNC-1:0] palette_capture,
    input wire logic [NUM_FUNC-1:0] palette_wr_hit,
    input wire logic [NUM_FUNC-1:0] init_req,
    input wire logic [NUM_FUNC-1:0] init_grant,
    input wire logic init_write_invalidate,
    input wire logic addr_par_err,
    input wire logic data_par_err,
    input wire logic [NUM_FUNC-1:0] master_active,
    input wire logic perr_seen,
    input wire logic [NUM_FUNC-1:0] data_parity_detected,
    input wire logic serr_drive,
    input wire logic perr_drive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence rd_other_s;
        cfg_rd && (cfg_offset != 8'h04 || cfg_func == 2'd3);
    endsequence
    resv_zero_a:
        assert property (cfg_rd |=> (cfg_rdata & 16'hfe98) == 16'h0000) else $error("fixed bits set");
    unmap_zero_a:
        assert property (rd_other_s |=> cfg_rdata == 16'h0000) else $error("unmapped read nonzero");
    wi_zero_a:
        assert property (init_write_invalidate == 1'b0) else $error("write invalidate issued");
    serr_gate_a:
        assert property (!addr_par_err |=> !serr_drive) else $error("serr without cause");
    perr_gate_a:
        assert property (!data_par_err |=> !perr_drive) else $error("perr without cause");
    grant_req_a:
        assert property ((init_grant & ~$past(init_req)) == '0) else $error("grant without request");
    spec_block_a:
        assert property (special_cycle |=> (claim | palette_capture) == '0) else $error("special");
    claim_hit_a:
        assert property ((claim & ~$past(mem_hit | io_hit)) == '0) else $error("claim without hit");
    cap_hit_a:
        assert property ((palette_capture & ~$past(palette_wr_hit)) == '0)
            else $error("capture without palette write");
    snoop_excl_a:
        assert property ((claim & palette_capture) == '0) else $error("snooped write claimed");
    dpar_set_a:
        assert property ((data_parity_detected & ~$past(data_parity_detected)
            & ~($past(master_active) & {NUM_FUNC{$past(perr_seen)}})) == '0)
            else $error("parity flag set without cause");
endmodule
bind pcc_command_bank pcc_command_bank_monitor #(.NUM_FUNC(NUM_FUNC))
    pcc_command_bank_monitor_i (.*);

// ### verification/pcc_command_bank_tb.sv
// self-checking bench for the command register bank
// assumes the host model drives configuration accesses
`timescale 1ns/10ps
module pcc_command_bank_tb;
    logic mclk = 0;
    logic reset_n = 0;
    logic cfg_wr, cfg_rd, special_cycle, addr_par_err, data_par_err, perr_seen;
    logic serr_drive, perr_drive, init_write_invalidate, rd_dly, pr_dly, probe = 0;
    logic [1:0] cfg_func, cfg_be;
    logic [7:0] cfg_offset;
    logic [15:0] cfg_wdata, cfg_rdata;
    logic [15:0] sh [3] = '{3{16'h0000}};
    logic [15:0] q [$];
    logic [2:0] mem_hit, io_hit, palette_wr_hit, init_req, master_active, data_parity_clear;
    logic [2:0] claim, palette_capture, init_grant, data_parity_detected;
    logic [2:0] init_mem_write = 3'b000;
    logic [31:0] bus_data, palette_data, lf = 32'hb1d8a951;
    logic [31:0] pd = 32'h0000_0000;
    logic [2:0] dp = 3'b000;
    int err_count = 0, compares = 0, cyc = 0;
    wire [15:0] obs_t = {6'h00, data_parity_detected, claim, palette_capture,
        init_write_invalidate};
    wire [15:0] obs_e = {11'h000, init_grant, serr_drive, perr_drive};
    pcc_command_bank #(.NUM_FUNC(3)) pcc_command_bank_i (.*);
    pcc_host_model pcc_host_model_i (.*);
    initial forever #50 mclk = ~mclk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        rd_dly <= cfg_rd & reset_n;
        pr_dly <= probe;
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_count++;
            results();
        end
    end
    always @(negedge mclk)
    begin
        if (rd_dly)
            check(cfg_rdata, q.pop_front());
        if (pr_dly)
        begin
            check(obs_t, q.pop_front());
            check(obs_e, q.pop_front());
            check(palette_data[31:16], q.pop_front());
            check(palette_data[15:0], q.pop_front());
        end
    end
    // ----
    // random write, read back, then bus probe
    // ----
    task automatic step();
        logic [1:0] f, be;
        logic [15:0] m;
        logic [2:0] ec, ep, eg, ed;
        logic se = 0;
        logic pe = 0;
        lf = nxt(lf);
        f = 2'(lf[7:0] % 8'd3);
        be = lf[9:8];
        m = (be[1] ? 16'h0100 : 16'h0000) | (be[0] ? 16'h0067 : 16'h0000);
        sh[f] = (sh[f] & ~m) | (lf[31:16] & m);
        pcc_host_model_i.acc(1'b1, f, 8'h04, be, lf[31:16]);
        q.push_back(sh[f]);
        pcc_host_model_i.acc(1'b0, f, 8'h04, 2'b11, lf[15:0]);
        q.push_back(sh[2'(lf[7:0] % 8'd3 + 8'd1) % 2'd3]);
        pcc_host_model_i.acc(1'b0, 2'(lf[7:0] % 8'd3 + 8'd1) % 2'd3, 8'h04, 2'b11, lf[15:0]);
        lf = nxt(lf);
        @(negedge mclk);
        {mem_hit, io_hit, palette_wr_hit, init_req, master_active, data_parity_clear} = lf[17:0];
        {special_cycle, addr_par_err, data_par_err, perr_seen} = {lf[31] & lf[30], lf[29:27]};
        bus_data = {lf[15:0], lf[31:16]};
        for (int k = 0; k < 3; k++)
        begin
            ec[k] = !special_cycle && !(palette_wr_hit[k] && sh[k][5])
                && (mem_hit[k] && sh[k][1] || io_hit[k] && sh[k][0]);
            ep[k] = !special_cycle && palette_wr_hit[k] && sh[k][5];
            eg[k] = init_req[k] && sh[k][2];
            ed[k] = perr_seen && master_active[k] && sh[k][6] || dp[k] && !data_parity_clear[k];
            se = se | sh[k][8];
            pe = pe | sh[k][6];
        end
        dp = ed;
        if (|ep)
            pd = bus_data;
        q.push_back({6'h00, ed, ec, ep, 1'b0});
        q.push_back({11'h000, eg, addr_par_err & se & pe, data_par_err & pe});
        q.push_back(pd[31:16]);
        q.push_back(pd[15:0]);
        probe = 1;
        @(negedge mclk);
        probe = 0;
        {mem_hit, io_hit, palette_wr_hit, init_req, master_active, data_parity_clear} = '0;
        {special_cycle, addr_par_err, data_par_err, perr_seen} = 4'h0;
    endtask
    initial
    begin
        {mem_hit, io_hit, palette_wr_hit, init_req, master_active, data_parity_clear} = '0;
        {special_cycle, addr_par_err, data_par_err, perr_seen, bus_data} = '0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1;
        repeat (20) step();
        // mid-run reset: enables, flags and captured data return to clear
        @(negedge mclk);
        reset_n = 0;
        sh = '{3{16'h0000}};
        dp = 3'b000;
        pd = 32'h0000_0000;
        repeat (2) @(negedge mclk);
        reset_n = 1;
        repeat (20) step();
        q.push_back(16'h0000);
        pcc_host_model_i.acc(1'b0, 2'd1, 8'h06, 2'b11, 16'h0000);
        q.push_back(16'h0000);
        pcc_host_model_i.acc(1'b0, 2'd3, 8'h04, 2'b11, 16'h0000);
        repeat (2) @(negedge mclk);
        results();
    end
endmodule

// ### verification/pcc_host_model.sv
// configuration software model for the command register bank
// assumes strobes change on the falling edge of mclk
`timescale 1ns/10ps
module pcc_host_model
(
    // clock
    input wire logic mclk,
    // configuration access
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [1:0] cfg_func,
    output logic [7:0] cfg_offset,
    output logic [1:0] cfg_be,
    output logic [15:0] cfg_wdata
);
    initial
    begin
        {cfg_wr, cfg_rd, cfg_func, cfg_offset, cfg_be, cfg_wdata} = '0;
    end
    // one access; released data shows the inverse of the last value
    task automatic acc(input logic w, input logic [1:0] f, input logic [7:0] o,
        input logic [1:0] be, input logic [15:0] d);
        @(negedge mclk);
        {cfg_wr, cfg_rd, cfg_func, cfg_offset, cfg_be, cfg_wdata} = {w, !w, f, o, be, d};
        @(negedge mclk);
        {cfg_wr, cfg_rd, cfg_wdata} = {2'b00, ~d};
    endtask
endmodule
